// *** pkg/adc_seq_defs.svh ***
// Operation
// R01: With a zero acquisition setting, setting go ends sampling and starts conversion at once.
// R02: With a zero acquisition setting, software waits the acquisition time itself before setting go.
// R03: The acquisition select field is bits 5 to 3 of control register two and resets to zero.
// R04: With a nonzero acquisition setting, go keeps sampling for the chosen bit periods, then converts.
// R05: On completion go clears, the done flag sets and sampling of the channel resumes.
// R06: No output shows whether acquisition has ended or conversion has begun; the code raises holding_capacitor_disconnect at conversion start.
// R07: A conversion lasts exactly eleven bit periods.
// R08: Clock select 000/100/001/101/010/110 gives 2/4/8/16/32/64 oscillator periods; x11 picks RC.
// R09: The holding capacitor is disconnected from the input when conversion begins.
// R10: Software picks the shortest bit period above about 2 us.
// R11: After a channel change, software allows the minimum acquisition time before converting.
// R12: With the RC clock above 1 MHz the device should sleep through the conversion.
// R13: Acquisition codes 111..000 give 20,16,12,8,6,4,2,0 bit periods.
// R14: With the RC clock one instruction cycle of delay precedes the converter clock.
// R15: On completion the result is loaded into the result register pair.
// R16: Justify set right-justifies the 10-bit result, cleared left-justifies it.
// R17: The bit period divides the oscillator by the selected ratio; intervals count bit periods.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define CTL2_JUSTIFY_BIT  7
`define CTL2_ACQ_HI       5
`define CTL2_ACQ_LO       3
`define CTL2_CLK_HI       2
`define CTL2_CLK_LO       0
`define CTL2_RESET        8'h00
`define CONV_BITS         4'hb
`define RESULT_W          10
`define INSTR_CYCLE_OSC   7'h04
`define RESTART_WAIT      5'h02
`endif

// *** pkg/adc_seq_pkg.sv ***
package adc_seq_pkg;
    typedef enum logic [2:0] {
        st_idle    = 3'b000,
        st_rcdelay = 3'b001,
        st_acquire = 3'b010,
        st_convert = 3'b011,
        st_wait    = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic       justify;
        logic [2:0] acq_sel;
        logic [2:0] clk_sel;
    } ctl_two_t;

    typedef struct packed {
        seq_state_t  state;
        logic [6:0]  div_cnt;
        logic [4:0]  tad_cnt;
        logic        go;
        logic        done_flag;
        logic        hold_disc;
        logic        core_start;
        logic [15:0] result_pair;
    } seq_regs_t;
endpackage

// *** rtl/adc_acquisition_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defs.svh"
module adc_acquisition_sequencer
    import adc_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Control register two
    input  wire logic [7:0]  converter_control_two,
    // Software go and flag clear
    input  wire logic        go_set,
    input  wire logic        go_clear,
    input  wire logic        done_flag_clear,
    // Internal RC clock tick, one cycle per bit period
    input  wire logic        internal_rc_clock,
    // Converter core
    input  wire logic        core_done,
    input  wire logic [9:0]  core_result,
    output logic             core_start,
    output logic             conv_bit_period,
    output logic             holding_capacitor_disconnect,
    // Status
    output logic             go_done,
    output logic             conversion_done_irq_flag,
    output logic [15:0]      result_register_pair
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    ctl_two_t   ctl;
    logic [6:0] div_ratio;
    logic [4:0] acq_periods;
    logic       use_rc;
    logic       tick;
    seq_regs_t  s_q;
    seq_regs_t  s_d;

    assign ctl.justify = converter_control_two[`CTL2_JUSTIFY_BIT];
    assign ctl.acq_sel = converter_control_two[`CTL2_ACQ_HI:`CTL2_ACQ_LO]; // [R03]
    assign ctl.clk_sel = converter_control_two[`CTL2_CLK_HI:`CTL2_CLK_LO];
    assign use_rc = (ctl.clk_sel[1:0] == 2'h3); // [R08]

    always_comb begin
        case (ctl.clk_sel) // [R08]
            3'b000:  div_ratio = 7'h02;
            3'b100:  div_ratio = 7'h04;
            3'b001:  div_ratio = 7'h08;
            3'b101:  div_ratio = 7'h10;
            3'b010:  div_ratio = 7'h20;
            3'b110:  div_ratio = 7'h40;
            default: div_ratio = 7'h02;
        endcase
    end

    always_comb begin
        case (ctl.acq_sel) // [R13]
            3'b111:  acq_periods = 5'h14;
            3'b110:  acq_periods = 5'h10;
            3'b101:  acq_periods = 5'h0c;
            3'b100:  acq_periods = 5'h08;
            3'b011:  acq_periods = 5'h06;
            3'b010:  acq_periods = 5'h04;
            3'b001:  acq_periods = 5'h02;
            default: acq_periods = 5'h00;
        endcase
    end

    // Bit period tick from divider or RC source
    assign tick = use_rc ? internal_rc_clock
                         : (s_q.div_cnt == div_ratio - 7'h01); // [R17]

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.core_start = 1'b0;
        if (s_q.state == st_idle || tick || use_rc) begin
            s_d.div_cnt = 7'h00;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 7'h01;
        end
        if (done_flag_clear) begin
            s_d.done_flag = 1'b0;
        end
        case (s_q.state)
            st_idle: begin
                s_d.hold_disc = 1'b0;
                if (go_set) begin
                    s_d.go = 1'b1;
                    s_d.tad_cnt = 5'h00;
                    if (use_rc) begin
                        s_d.div_cnt = 7'h00;
                        s_d.state = st_rcdelay; // [R14]
                    end else if (acq_periods == 5'h00) begin
                        s_d.state = st_convert; // [R01]
                        s_d.hold_disc = 1'b1; // [R09]
                        s_d.core_start = 1'b1;
                    end else begin
                        s_d.state = st_acquire; // [R04]
                    end
                end
            end
            st_rcdelay: begin
                s_d.div_cnt = s_q.div_cnt + 7'h01;
                if (s_q.div_cnt == `INSTR_CYCLE_OSC - 7'h01) begin // [R14]
                    s_d.div_cnt = 7'h00;
                    s_d.state = (acq_periods == 5'h00) ? st_convert : st_acquire;
                    s_d.hold_disc = (acq_periods == 5'h00); // [R09]
                    s_d.core_start = (acq_periods == 5'h00);
                end
            end
            st_acquire: begin
                if (tick) begin
                    s_d.tad_cnt = s_q.tad_cnt + 5'h01;
                    if (s_q.tad_cnt + 5'h01 == acq_periods) begin // [R04]
                        s_d.tad_cnt = 5'h00;
                        s_d.state = st_convert;
                        s_d.hold_disc = 1'b1; // [R09]
                        s_d.core_start = 1'b1;
                    end
                end
            end
            st_convert: begin
                if (tick) begin
                    s_d.tad_cnt = s_q.tad_cnt + 5'h01;
                    if (s_q.tad_cnt + 5'h01 == {1'b0, `CONV_BITS}) begin // [R07]
                        s_d.go = 1'b0; // [R05]
                        s_d.done_flag = 1'b1; // [R05]
                        s_d.hold_disc = 1'b0; // [R05]
                        s_d.tad_cnt = 5'h00;
                        s_d.state = st_wait;
                        if (ctl.justify) begin // [R16]
                            s_d.result_pair = {6'h00, core_result}; // [R15]
                        end else begin
                            s_d.result_pair = {core_result, 6'h00}; // [R15]
                        end
                    end
                end
            end
            st_wait: begin
                if (tick) begin
                    s_d.tad_cnt = s_q.tad_cnt + 5'h01;
                    if (s_q.tad_cnt + 5'h01 == `RESTART_WAIT) begin
                        s_d.tad_cnt = 5'h00;
                        s_d.state = st_idle;
                    end
                end
            end
            default: s_d.state = st_idle;
        endcase
        // Abort leaves the result untouched unless it meets the last conversion tick, which still loads it
        if (go_clear && s_q.state != st_idle && s_q.state != st_wait) begin
            s_d.go = 1'b0;
            s_d.hold_disc = 1'b0;
            s_d.tad_cnt = 5'h00;
            s_d.state = st_wait;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{state: st_idle, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign core_start = s_q.core_start;
    assign conv_bit_period = tick && (s_q.state == st_convert);
    assign holding_capacitor_disconnect = s_q.hold_disc; // [R09]
    assign go_done = s_q.go; // [R06]
    assign conversion_done_irq_flag = s_q.done_flag;
    assign result_register_pair = s_q.result_pair;

endmodule
`default_nettype wire

// *** verification/adc_acquisition_sequencer_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_acquisition_sequencer_test;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  ctl = 8'h00;
    logic        go = 1'b0;
    logic        stop = 1'b0;
    logic        fclr = 1'b0;
    logic        rc, cdone, cs, disc, busy, flag;
    logic [9:0]  cres;
    logic [9:0]  ev = 10'h3a1;
    logic [15:0] res;
    logic [15:0] er;
    int          num_errors = 0;
    int          total_checks = 0;
    int          n;
    logic        bp;
    int          nb;
    // Clock selects span all ratios
    logic [18:0] rows [7] = '{{8'h88, 11'd26}, {8'h3c, 11'd124},
        {8'h91, 11'd120}, {8'h1d, 11'd272}, {8'ha2, 11'd608},
        {8'h2e, 11'd1472}, {8'hb3, 11'd0}};
    always #25 clk = ~clk;
    adc_acquisition_sequencer i_dut (.clk(clk), .resetn(resetn),
        .converter_control_two(ctl), .go_set(go), .go_clear(stop),
        .done_flag_clear(fclr), .internal_rc_clock(rc), .core_done(cdone),
        .core_result(cres), .core_start(cs), .conv_bit_period(bp),
        .holding_capacitor_disconnect(disc), .go_done(busy),
        .conversion_done_irq_flag(flag), .result_register_pair(res));
    adc_core_model i_core (.clk(clk), .core_start(cs),
        .holding_capacitor_disconnect(disc), .internal_rc_clock(rc),
        .core_done(cdone), .core_result(cres));
    task automatic print_verdict;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic run(input logic [7:0] c);
        ctl <= c;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        #1 n = 0;
        nb = (bp === 1'b1) ? 1 : 0;
        while (busy === 1'b1) begin
            @(posedge clk) #1 n++;
            if (bp === 1'b1)
                nb++;
            if (n > 2000) begin
                num_errors++;
                print_verdict();
            end
        end
        ev = ev + 10'h0d3;
        er = c[7] ? {6'h00, ev} : {ev, 6'h00};
        chk({15'h0, flag}, 16'h0001);
        chk(16'(nb), 16'd11);
        chk(res, er);
        @(posedge clk) fclr <= 1'b1;
        @(posedge clk) fclr <= 1'b0;
        #1 chk({15'h0, flag}, 16'h0000);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        chk({res[14:0], busy}, 16'h0000);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            run(rows[i][18:11]);
            if (rows[i][10:0] != 11'd0)
                chk(16'(n), {5'h0, rows[i][10:0]});
            // Idle gap covers channel settling
            repeat (140) @(posedge clk);
        end
        // Go during the post-conversion wait is refused
        run(8'h06);
        chk(16'(n), 16'd704);
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        #1 chk({15'h0, busy}, 16'h0000);
        repeat (140) @(posedge clk);
        // Abort in acquisition keeps the old result
        ctl <= 8'h3c;
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (10) @(posedge clk);
        stop <= 1'b1;
        @(posedge clk) stop <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk({14'h0, busy, flag}, 16'h0000);
        chk(res, er);
        print_verdict();
    end
endmodule
`default_nettype wire

// *** verification/adc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
    // Sequencer side
    input  wire logic clk,
    input  wire logic core_start,
    input  wire logic holding_capacitor_disconnect,
    output logic      internal_rc_clock,
    output logic      core_done,
    output logic [9:0] core_result
);
    logic [9:0] v_q = 10'h3a1;
    logic [2:0] t_q = 3'h0;
    always_ff @(posedge clk) begin
        t_q <= (t_q == 3'h4) ? 3'h0 : t_q + 3'h1;
        if (core_start)
            v_q <= v_q + 10'h0d3;
    end
    // Free running RC tick, device assumed asleep
    assign internal_rc_clock = (t_q == 3'h4);
    assign core_done = 1'b0;
    // Code valid only while isolated
    assign core_result = holding_capacitor_disconnect ? v_q : ~v_q;
endmodule
`default_nettype wire

// *** verification/adc_seq_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module adc_seq_monitor (
    // Watched ports
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  converter_control_two,
    input wire logic        core_start,
    input wire logic        holding_capacitor_disconnect,
    input wire logic        go_done,
    input wire logic        conversion_done_irq_flag,
    input wire logic [15:0] result_register_pair
);
    logic [7:0]  k;
    logic [2:0]  e;
    logic        d;
    logic        f;
    logic [15:0] r;
    logic [10:0] n_q;
    assign k = converter_control_two;
    assign d = holding_capacitor_disconnect;
    assign f = conversion_done_irq_flag;
    assign r = result_register_pair;
    assign e = 3'd1 + {2'b0, k[2]} + {1'b0, k[0], 1'b0} + {k[1], 2'b0};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            n_q <= 11'h000;
        else
            n_q <= d ? n_q + 11'h001 : 11'h000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_acq; !core_start [*4] ##1 core_start; endsequence
    property p_imm;
        $rose(go_done) && k[5:3] == 3'b000 && k[1:0] != 2'b11
            |-> core_start && d;
    endproperty
    a_imm: assert property (p_imm) else $error("late start");
    property p_acq; $rose(go_done) && k[5:0] == 6'h08 |-> s_acq; endproperty
    a_acq: assert property (p_acq) else $error("acq time");
    property p_pulse; core_start |=> !core_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start width");
    property p_disc; $rose(d) |-> core_start; endproperty
    a_disc: assert property (p_disc) else $error("disconnect");
    property p_len;
        $fell(d) && $rose(f) && k[1:0] != 2'b11 |-> n_q == (11'd11 << e);
    endproperty
    a_len: assert property (p_len) else $error("length");
    property p_done; $rose(f) |-> $fell(go_done); endproperty
    a_done: assert property (p_done) else $error("done");
    property p_res; $changed(r) |-> $fell(go_done); endproperty
    a_res: assert property (p_res) else $error("result load");
    property p_just; $changed(r) |-> (k[7] ? r[15:10] : r[5:0]) == 6'h00;
    endproperty
    a_just: assert property (p_just) else $error("justify");
endmodule
bind adc_acquisition_sequencer adc_seq_monitor i_mon (.clk(clk),
    .resetn(resetn), .converter_control_two(converter_control_two),
    .core_start(core_start),
    .holding_capacitor_disconnect(holding_capacitor_disconnect),
    .go_done(go_done), .conversion_done_irq_flag(conversion_done_irq_flag),
    .result_register_pair(result_register_pair));
`default_nettype wire
